// file: logic/nib_port_pkg.sv
// constants for the nibble handshake port and antenna drive controller
// assumes an APB master with 32-bit data and one 100 MHz clock
package nib_port_pkg;
   // -----------------------------------------------------------------
   // register indices and byte addresses
   // -----------------------------------------------------------------
   localparam logic [11:0] OFS_REQUEST = 12'h000;
   localparam logic [11:0] OFS_COMMAND = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_FETCH = 12'h00C;
   localparam logic [11:0] OFS_RANGE = 12'h010;
   localparam logic [11:0] OFS_CURSOR = 12'h014;
   localparam logic [11:0] OFS_CURSOR_AZ = 12'h018;
   localparam logic [11:0] OFS_DL_AZ = 12'h01C;
   localparam logic [11:0] OFS_SLEW = 12'h020;
   localparam logic [9:0] IDX_DRIVE = 10'h0F1;
   localparam logic [9:0] IDX_CONTROL = 10'h0F2;
   localparam logic [11:0] OFS_DRIVE = {IDX_DRIVE, 2'b00};
   localparam logic [11:0] OFS_CONTROL = {IDX_CONTROL, 2'b00};
   // -----------------------------------------------------------------
   // command bits, fields, reset values
   // -----------------------------------------------------------------
   localparam int CMD_SINGLE = 0;
   localparam int CMD_FETCH = 1;
   localparam int CMD_REPORT = 2;
   localparam int CMD_EN_SET = 3;
   localparam int CMD_EN_CLR = 4;
   localparam int CTRL_ENABLE_BIT = 2;
   localparam logic [7:0] DRIVE_RESET = 8'h88;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] REQUEST_RESET = 8'h00;
   localparam logic [3:0] SEL_MODE_READ = 4'hE;
   localparam logic [3:0] SEL_MODE_STEP = 4'hF;
   localparam logic [3:0] SEL_LAST_DATA = 4'hB;
   localparam logic [1:0] MODE_SEND = 2'h3;
   localparam logic [3:0] FRESH_NIBBLE = 4'h4;
   localparam logic [1:0] FETCH_LAST = 2'h3;
   localparam logic [1:0] SRC_CURSOR = 2'h1;
   localparam logic [1:0] SRC_DOWNLOAD = 2'h2;
   typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT} xfer_state_t;
   typedef enum {K_SINGLE, K_FETCH, K_REPORT, K_MODE} xfer_kind_t;
endpackage

// file: logic/nib_port.sv
// nibble handshake controller with range report and antenna drive port
// assumes synchronous adapter pins and an APB master on clk_sys
//
// Notes on behaviour
// - select and strobe start every transfer, acknowledge ends
// - select 14 returns adapter mode number
// - select 15 steps mode, 3 wraps to 0
// - modes 0-2 receive nibbles, mode 3 sends
// - nibble 4 top bit zero when cursor fresh
// - nibbles 0-3 range, always new
// - pending flag set before strobe, acknowledge clears
// - request word: select low, data high
// - send leaves request word unchanged
// - reads return nibble in request high bits
// - fetch four consecutive selects into 16 bits
// - report sends nibbles 0-11, range MSN first
// - slew source picks cursor or downloaded azimuth
// - drive port: elevation high, azimuth low
// - code 8 means no drive on axis
// - code 15 max clockwise/up, 0 max opposite
// - control bit 2 enables both converters
// - enable changed through whole-byte shadow copy
// - report request flag starts background report
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module nib_port (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [3:0] host_select,
   output logic host_transfer_strobe,
   input wire logic adapter_acknowledge,
   input wire logic [3:0] host_data_in,
   output logic [3:0] host_data_out,
   output logic host_data_oe_n,
   output logic [7:0] antenna_drive_codes,
   output logic [7:0] shared_control_port
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   nib_port_pkg::xfer_state_t state, next_state;
   nib_port_pkg::xfer_kind_t kind, next_kind;
   logic [7:0] transfer_request_word, next_transfer_request_word;
   logic [7:0] next_drive, next_control;
   logic [15:0] range_est, next_range_est, fetch_result, next_fetch_result;
   logic [31:0] cursor_data, next_cursor_data;
   logic [15:0] cursor_azimuth_store, next_cursor_azimuth_store;
   logic [15:0] downloaded_azimuth_store, next_downloaded_azimuth_store;
   logic [15:0] slew_target, next_slew_target;
   logic [1:0] slew_source_flag, next_slew_source_flag;
   logic [1:0] mode, next_mode;
   logic mode_known, next_mode_known, cursor_fresh, next_cursor_fresh;
   logic transfer_pending_flag, next_pending;
   logic report_request_flag, next_report_request_flag;
   logic single_req, next_single_req, fetch_req, next_fetch_req;
   logic rpt_active, next_rpt_active, send_dir, next_send_dir;
   logic [3:0] rpt_idx, next_rpt_idx, next_select, next_dout;
   logic [1:0] fetch_idx, next_fetch_idx;
   logic [11:0] fetch_acc, next_fetch_acc;
   logic next_strobe, next_oe_n;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic wr_take, acked, busy;
   logic [47:0] report_bits;
   logic [3:0] rpt_nibble;

   assign wr_take = psel & penable & pready & pwrite;
   assign acked = (state == nib_port_pkg::ST_WAIT) & adapter_acknowledge;
   // busy spans the idle gaps between nibbles of a fetch or report
   assign busy = (state != nib_port_pkg::ST_IDLE) | single_req | fetch_req | rpt_active
      | report_request_flag;
   assign report_bits = {range_est, cursor_data};
   assign rpt_nibble = report_bits[6'(47 - 4 * rpt_idx) -: 4];

   // -----------------------------------------------------------------
   // APB slave: one wait state, read data and error from flops
   // -----------------------------------------------------------------
   always_comb begin
      next_pready = psel & penable & ~pready;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (psel & penable & ~pready) begin
         unique case (paddr)
            nib_port_pkg::OFS_REQUEST: next_prdata = {24'h00_0000, transfer_request_word};
            nib_port_pkg::OFS_COMMAND: next_prdata = 32'h0000_0000;
            nib_port_pkg::OFS_STATUS: next_prdata = {26'h000_0000, cursor_fresh, mode,
               report_request_flag, busy, transfer_pending_flag};
            nib_port_pkg::OFS_FETCH: next_prdata = {16'h0000, fetch_result};
            nib_port_pkg::OFS_RANGE: next_prdata = {16'h0000, range_est};
            nib_port_pkg::OFS_CURSOR: next_prdata = cursor_data;
            nib_port_pkg::OFS_CURSOR_AZ: next_prdata = {16'h0000, cursor_azimuth_store};
            nib_port_pkg::OFS_DL_AZ: next_prdata = {16'h0000, downloaded_azimuth_store};
            nib_port_pkg::OFS_SLEW: next_prdata = {slew_target, 14'h0000, slew_source_flag};
            nib_port_pkg::OFS_DRIVE: next_prdata = 32'h0000_0000;
            nib_port_pkg::OFS_CONTROL: next_prdata = {24'h00_0000, shared_control_port};
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // -----------------------------------------------------------------
   // transfer sequencer, report, fetch, drive and control ports
   // -----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_kind = kind;
      next_transfer_request_word = transfer_request_word;
      next_drive = antenna_drive_codes;
      next_control = shared_control_port;
      next_range_est = range_est;
      next_fetch_result = fetch_result;
      next_cursor_data = cursor_data;
      next_cursor_azimuth_store = cursor_azimuth_store;
      next_downloaded_azimuth_store = downloaded_azimuth_store;
      next_slew_source_flag = slew_source_flag;
      next_slew_target = slew_target;
      next_mode = mode;
      next_mode_known = mode_known;
      next_cursor_fresh = cursor_fresh;
      next_pending = transfer_pending_flag;
      next_report_request_flag = report_request_flag;
      next_single_req = single_req;
      next_fetch_req = fetch_req;
      next_rpt_active = rpt_active;
      next_rpt_idx = rpt_idx;
      next_fetch_idx = fetch_idx;
      next_fetch_acc = fetch_acc;
      next_send_dir = send_dir;
      next_select = host_select;
      next_dout = host_data_out;
      next_strobe = 1'b0;
      next_oe_n = host_data_oe_n;
      // slew target follows the selected azimuth store
      if (slew_source_flag == nib_port_pkg::SRC_CURSOR) begin
         next_slew_target = cursor_azimuth_store;
      end else if (slew_source_flag == nib_port_pkg::SRC_DOWNLOAD) begin
         next_slew_target = downloaded_azimuth_store;
      end
      unique case (state)
         nib_port_pkg::ST_IDLE: begin
            next_oe_n = 1'b1;
            if (single_req) begin
               next_single_req = 1'b0;
               next_kind = nib_port_pkg::K_SINGLE;
               next_select = transfer_request_word[3:0];
               next_dout = transfer_request_word[7:4];
               next_state = nib_port_pkg::ST_SETUP;
            end else if (fetch_req) begin
               next_kind = nib_port_pkg::K_FETCH;
               next_select = transfer_request_word[3:0] + {2'b00, fetch_idx};
               next_state = nib_port_pkg::ST_SETUP;
            end else if (rpt_active) begin
               // background report yields to any software transfer above
               next_state = nib_port_pkg::ST_SETUP;
               if (!mode_known) begin
                  next_kind = nib_port_pkg::K_MODE;
                  next_select = nib_port_pkg::SEL_MODE_READ;
               end else if (mode != nib_port_pkg::MODE_SEND) begin
                  next_kind = nib_port_pkg::K_MODE;
                  next_select = nib_port_pkg::SEL_MODE_STEP;
               end else begin
                  next_kind = nib_port_pkg::K_REPORT;
                  next_select = rpt_idx;
                  next_dout = rpt_nibble;
                  if (rpt_idx == nib_port_pkg::FRESH_NIBBLE) begin
                     next_dout[3] = ~cursor_fresh;
                  end
               end
            end else if (report_request_flag) begin
               next_report_request_flag = 1'b0;
               next_rpt_active = 1'b1;
               next_rpt_idx = 4'h0;
            end
         end
         nib_port_pkg::ST_SETUP: begin
            // select and data settle two cycles ahead of the strobe, the output enable one cycle ahead
            next_send_dir = mode_known && mode == nib_port_pkg::MODE_SEND
               && host_select <= nib_port_pkg::SEL_LAST_DATA;
            next_oe_n = ~next_send_dir;
            next_pending = 1'b1;
            next_state = nib_port_pkg::ST_STROBE;
         end
         nib_port_pkg::ST_STROBE: begin
            next_strobe = 1'b1;
            next_state = nib_port_pkg::ST_WAIT;
         end
         nib_port_pkg::ST_WAIT: begin
            if (adapter_acknowledge) begin
               next_pending = 1'b0;
               next_state = nib_port_pkg::ST_IDLE;
               if (host_select >= nib_port_pkg::SEL_MODE_READ) begin
                  next_mode = host_data_in[1:0];
                  next_mode_known = 1'b1;
               end
               unique case (kind)
                  nib_port_pkg::K_SINGLE: begin
                     if (!send_dir) begin
                        next_transfer_request_word[7:4] = host_data_in;
                     end
                  end
                  nib_port_pkg::K_FETCH: begin
                     next_fetch_acc = {fetch_acc[7:0], host_data_in};
                     next_fetch_idx = fetch_idx + 2'd1;
                     if (fetch_idx == nib_port_pkg::FETCH_LAST) begin
                        next_fetch_result = {fetch_acc, host_data_in};
                        next_fetch_req = 1'b0;
                     end
                  end
                  nib_port_pkg::K_REPORT: begin
                     next_rpt_idx = rpt_idx + 4'h1;
                     if (rpt_idx == nib_port_pkg::SEL_LAST_DATA) begin
                        next_rpt_active = 1'b0;
                        next_cursor_fresh = 1'b0;
                     end
                  end
                  nib_port_pkg::K_MODE: begin
                  end
               endcase
            end
         end
      endcase
      // software writes; software sets win over hardware clears, except a fetch command while a fetch is still running
      if (wr_take) begin
         unique case (paddr)
            nib_port_pkg::OFS_REQUEST: begin
               if (!busy) begin
                  next_transfer_request_word = pwdata[7:0];
               end
            end
            nib_port_pkg::OFS_COMMAND: begin
               if (pwdata[nib_port_pkg::CMD_SINGLE]) begin
                  next_single_req = 1'b1;
               end
               if (pwdata[nib_port_pkg::CMD_FETCH] && !fetch_req) begin
                  next_fetch_req = 1'b1;
                  next_fetch_idx = 2'd0;
               end
               if (pwdata[nib_port_pkg::CMD_REPORT]) begin
                  next_report_request_flag = 1'b1;
               end
               if (pwdata[nib_port_pkg::CMD_EN_SET]) begin
                  next_control[nib_port_pkg::CTRL_ENABLE_BIT] = 1'b1;
               end else if (pwdata[nib_port_pkg::CMD_EN_CLR]) begin
                  next_control[nib_port_pkg::CTRL_ENABLE_BIT] = 1'b0;
               end
            end
            nib_port_pkg::OFS_RANGE: next_range_est = pwdata[15:0];
            nib_port_pkg::OFS_CURSOR: begin
               next_cursor_data = pwdata;
               next_cursor_fresh = 1'b1;
            end
            nib_port_pkg::OFS_CURSOR_AZ: next_cursor_azimuth_store = pwdata[15:0];
            nib_port_pkg::OFS_DL_AZ: next_downloaded_azimuth_store = pwdata[15:0];
            nib_port_pkg::OFS_SLEW: next_slew_source_flag = pwdata[1:0];
            nib_port_pkg::OFS_DRIVE: next_drive = pwdata[7:0];
            nib_port_pkg::OFS_CONTROL: next_control = pwdata[7:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= nib_port_pkg::ST_IDLE;
         kind <= nib_port_pkg::K_SINGLE;
         transfer_request_word <= nib_port_pkg::REQUEST_RESET;
         antenna_drive_codes <= nib_port_pkg::DRIVE_RESET;
         shared_control_port <= nib_port_pkg::CONTROL_RESET;
         transfer_pending_flag <= 1'b0;
         range_est <= 16'h0000;
         fetch_result <= 16'h0000;
         cursor_data <= 32'h0000_0000;
         cursor_azimuth_store <= 16'h0000;
         downloaded_azimuth_store <= 16'h0000;
         slew_source_flag <= 2'h0;
         slew_target <= 16'h0000;
         mode <= 2'h0;
         mode_known <= 1'b0;
         cursor_fresh <= 1'b0;
         report_request_flag <= 1'b0;
         single_req <= 1'b0;
         fetch_req <= 1'b0;
         rpt_active <= 1'b0;
         rpt_idx <= 4'h0;
         fetch_idx <= 2'd0;
         fetch_acc <= 12'h000;
         send_dir <= 1'b0;
         host_select <= 4'h0;
         host_data_out <= 4'h0;
         host_transfer_strobe <= 1'b0;
         host_data_oe_n <= 1'b1;
      end else begin
         state <= next_state;
         kind <= next_kind;
         transfer_request_word <= next_transfer_request_word;
         antenna_drive_codes <= next_drive;
         shared_control_port <= next_control;
         transfer_pending_flag <= next_pending;
         range_est <= next_range_est;
         fetch_result <= next_fetch_result;
         cursor_data <= next_cursor_data;
         cursor_azimuth_store <= next_cursor_azimuth_store;
         downloaded_azimuth_store <= next_downloaded_azimuth_store;
         slew_source_flag <= next_slew_source_flag;
         slew_target <= next_slew_target;
         mode <= next_mode;
         mode_known <= next_mode_known;
         cursor_fresh <= next_cursor_fresh;
         report_request_flag <= next_report_request_flag;
         single_req <= next_single_req;
         fetch_req <= next_fetch_req;
         rpt_active <= next_rpt_active;
         rpt_idx <= next_rpt_idx;
         fetch_idx <= next_fetch_idx;
         fetch_acc <= next_fetch_acc;
         send_dir <= next_send_dir;
         host_select <= next_select;
         host_data_out <= next_dout;
         host_transfer_strobe <= next_strobe;
         host_data_oe_n <= next_oe_n;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_strobe_single_pulse: assert property (@(posedge clk_sys) disable iff (srst)
      host_transfer_strobe |=> !host_transfer_strobe && transfer_pending_flag)
      else $error("strobe longer than one cycle");
   a_pending_at_strobe: assert property (@(posedge clk_sys) disable iff (srst)
      host_transfer_strobe |-> transfer_pending_flag && $past(transfer_pending_flag))
      else $error("pending flag not set before strobe");
   a_ack_clears_pending: assert property (@(posedge clk_sys) disable iff (srst)
      acked |=> !transfer_pending_flag && !host_transfer_strobe)
      else $error("acknowledge did not clear pending flag");
   a_pins_held: assert property (@(posedge clk_sys) disable iff (srst)
      (transfer_pending_flag && !acked) |=> $stable(host_select) && $stable(host_data_out)
         && $stable(host_data_oe_n))
      else $error("select or data moved before acknowledge");
   a_send_only_mode3: assert property (@(posedge clk_sys) disable iff (srst)
      !host_data_oe_n |-> mode == nib_port_pkg::MODE_SEND && host_select <= 4'hB)
      else $error("data driven outside mode 3 data select");
   a_read_returns: assert property (@(posedge clk_sys) disable iff (srst)
      (acked && kind == nib_port_pkg::K_SINGLE && !send_dir)
         |=> transfer_request_word[7:4] == $past(host_data_in))
      else $error("read nibble not returned in request word");
   a_fresh_bit: assert property (@(posedge clk_sys) disable iff (srst)
      (host_transfer_strobe && kind == nib_port_pkg::K_REPORT && host_select == 4'h4)
         |-> host_data_out[3] == !cursor_fresh)
      else $error("freshness bit wrong in nibble 4");
   a_reset_safe: assert property (@(posedge clk_sys)
      srst |=> antenna_drive_codes == 8'h88 && !shared_control_port[2]
         && !transfer_pending_flag)
      else $error("reset left drive enabled");
   a_slew_source: assert property (@(posedge clk_sys) disable iff (srst)
      (slew_source_flag == 2'h2)
         |=> slew_target == $past(downloaded_azimuth_store))
      else $error("slew target not the downloaded azimuth");
endmodule

// file: dv/adapter_model.sv
// behavioural nibble adapter facing the port's strobe and acknowledge pins
// assumes synchronous pins on clk_sys and a strobe that lasts one cycle
`timescale 1ns/1ps
module adapter_model (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [3:0] host_select,
   input wire logic host_transfer_strobe,
   input wire logic [3:0] host_data_out,
   input wire logic host_data_oe_n,
   input wire logic [2:0] ack_delay,
   output logic adapter_acknowledge = 1'b0,
   output logic [3:0] host_data_in = 4'h0
);
   // ----------------------------------------------------------------
   // mode, handshake and capture of sent nibbles
   // ----------------------------------------------------------------
   logic [1:0] mode = 2'h0;
   logic [2:0] cnt = 3'h0;
   logic [3:0] sel_held;
   logic [3:0] dat_held;
   logic [3:0] log_mem [0:31];
   logic [4:0] log_cnt = 5'h00;
   int hold_faults = 0;
   always @(posedge clk_sys) begin
      adapter_acknowledge <= 1'b0;
      host_data_in <= ~host_data_in;
      if (srst) begin
         mode <= 2'h0;
         cnt <= 3'h0;
         log_cnt <= 5'h00;
      end else if (host_transfer_strobe) begin
         cnt <= ack_delay;
         sel_held <= host_select;
         dat_held <= host_data_out;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
         if (host_select !== sel_held) hold_faults++;
         if (cnt == 3'h1) begin
            adapter_acknowledge <= 1'b1;
            if (sel_held == 4'hE) begin
               host_data_in <= {2'b00, mode};
            end else if (sel_held == 4'hF) begin
               mode <= mode + 2'h1;
               host_data_in <= {2'b00, mode + 2'h1};
            end else if (mode == 2'h3) begin
               if (host_data_out !== dat_held || host_data_oe_n !== 1'b0) hold_faults++;
               log_mem[log_cnt] <= host_data_out;
               log_cnt <= log_cnt + 5'h01;
            end else begin
               host_data_in <= sel_held ^ 4'hA;
            end
         end
      end
   end
endmodule

// file: dv/nibble_handshake_port_and_antenna_drive_tb.sv
// self-checking bench for the nibble port: apb master, adapter model, checks
// assumes the port answers apb with one wait state and clk_sys at 100 MHz
`timescale 1ns/1ps
module nibble_handshake_port_and_antenna_drive_tb;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, strobe, ack, oe_n;
   logic [3:0] sel, din, dout, b;
   logic [7:0] drv, ctl, r;
   logic [2:0] ack_delay = 3'h1;
   logic [15:0] rng, az_a, az_b;
   logic [31:0] cur;
   int seed = 32'h791BA4FC;
   int err_total = 0, comparisons = 0, k, n;
   always #5 clk_sys = ~clk_sys;
   nib_port i_nib_port (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .host_select(sel), .host_transfer_strobe(strobe),
      .adapter_acknowledge(ack), .host_data_in(din), .host_data_out(dout),
      .host_data_oe_n(oe_n), .antenna_drive_codes(drv), .shared_control_port(ctl));
   adapter_model i_adapter_model (.clk_sys(clk_sys), .srst(srst), .host_select(sel),
      .host_transfer_strobe(strobe), .host_data_out(dout), .host_data_oe_n(oe_n),
      .ack_delay(ack_delay), .adapter_acknowledge(ack), .host_data_in(din));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [3:0] exp_nib(input logic [15:0] rg, input logic [31:0] cu,
      input int i, input logic stale);
      logic [3:0] v;
      v = (i < 4) ? rg[15 - 4 * i -: 4] : cu[31 - 4 * (i - 4) -: 4];
      if (i == 4) v[3] = stale;
      return v;
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // let the edge's register updates settle before anyone looks
      #1;
   endtask
   task automatic go(input logic [31:0] cmd);
      ack_delay <= 3'h1 + 3'($random(seed) & 3);
      apb(1'b1, nib_port_pkg::OFS_COMMAND, cmd);
      n = 0;
      do begin
         apb(1'b0, nib_port_pkg::OFS_STATUS, 32'h0);
         n++;
      end while (q[1] !== 1'b0 && n < 100);
      chk("pending", {30'h0, q[1:0]}, 32'h0);
   endtask
   task automatic final_report;
      if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      final_report;
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      chk("drive_rst", {24'h0, drv}, 32'h88);
      chk("ctl_rst", {24'h0, ctl}, 32'h00);
      apb(1'b0, nib_port_pkg::OFS_STATUS, 32'h0);
      chk("status_rst", q & 32'h7, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped", {31'h0, e}, 32'h1);
      for (k = 0; k < 4; k++) begin
         r = (k == 0) ? 8'hF0 : (k == 1) ? 8'h0F : (k == 2) ? 8'h88 : 8'($random(seed));
         apb(1'b1, nib_port_pkg::OFS_DRIVE, {24'h0, r});
         chk("drive_port", {24'h0, drv}, {24'h0, r});
         apb(1'b0, nib_port_pkg::OFS_DRIVE, 32'h0);
         chk("drive_wo", q, 32'h0);
      end
      r = 8'($random(seed)) & 8'hFB;
      apb(1'b1, nib_port_pkg::OFS_CONTROL, {24'h0, r});
      go(32'h08);
      chk("enable_set", {24'h0, ctl}, {24'h0, r | 8'h04});
      go(32'h10);
      chk("enable_clr", {24'h0, ctl}, {24'h0, r});
      go(32'h18);
      chk("enable_both", {24'h0, ctl}, {24'h0, r | 8'h04});
      for (k = 0; k < 6; k++) begin
         b = 4'($unsigned($random(seed)) % 12);
         apb(1'b1, nib_port_pkg::OFS_REQUEST, {24'h0, 4'h5, b});
         go(32'h01);
         apb(1'b0, nib_port_pkg::OFS_REQUEST, 32'h0);
         chk("read_req", q, {24'h0, b ^ 4'hA, b});
      end
      b = 4'($unsigned($random(seed)) % 9);
      apb(1'b1, nib_port_pkg::OFS_REQUEST, {24'h0, b});
      go(32'h02);
      apb(1'b0, nib_port_pkg::OFS_FETCH, 32'h0);
      chk("fetch", q, {16'h0, b ^ 4'hA, (b + 4'h1) ^ 4'hA, (b + 4'h2) ^ 4'hA,
         (b + 4'h3) ^ 4'hA});
      for (k = 0; k < 2; k++) begin
         rng = 16'($random(seed));
         cur = $random(seed);
         apb(1'b1, nib_port_pkg::OFS_RANGE, {16'h0, rng});
         if (k == 0) apb(1'b1, nib_port_pkg::OFS_CURSOR, cur);
         else cur = {4'h0, cur[27:0]};
         if (k == 1) apb(1'b0, nib_port_pkg::OFS_CURSOR, 32'h0);
         if (k == 1) cur = q;
         go(32'h04);
         for (n = 0; n < 12; n++) begin
            b = exp_nib(rng, cur, n, k == 1);
            chk("report", {28'h0, i_adapter_model.log_mem[12 * k + n]}, {28'h0, b});
         end
      end
      apb(1'b0, nib_port_pkg::OFS_STATUS, 32'h0);
      chk("mode3", {30'h0, q[4:3]}, 32'h3);
      r = 8'($random(seed)) & 8'hF7;
      apb(1'b1, nib_port_pkg::OFS_REQUEST, {24'h0, r});
      go(32'h01);
      apb(1'b0, nib_port_pkg::OFS_REQUEST, 32'h0);
      chk("send_keep", q, {24'h0, r});
      chk("send_nib", {28'h0, i_adapter_model.log_mem[24]}, {28'h0, r[7:4]});
      apb(1'b1, nib_port_pkg::OFS_REQUEST, 32'h0E);
      go(32'h01);
      apb(1'b0, nib_port_pkg::OFS_REQUEST, 32'h0);
      chk("mode_read", q, 32'h3E);
      az_a = 16'($random(seed));
      az_b = 16'($random(seed));
      apb(1'b1, nib_port_pkg::OFS_CURSOR_AZ, {16'h0, az_a});
      apb(1'b1, nib_port_pkg::OFS_DL_AZ, {16'h0, az_b});
      for (k = 1; k < 3; k++) begin
         apb(1'b1, nib_port_pkg::OFS_SLEW, k);
         apb(1'b0, nib_port_pkg::OFS_SLEW, 32'h0);
         chk("slew", {16'h0, q[31:16]}, {16'h0, (k == 1) ? az_a : az_b});
      end
      chk("hold", i_adapter_model.hold_faults, 32'h0);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      #1;
      chk("drive_rst2", {24'h0, drv}, 32'h88);
      chk("ctl_rst2", {24'h0, ctl}, 32'h00);
      final_report;
   end
endmodule
